// ---- src/cpi_pkg.sv ----
// Package with constants and carrier types for the core side of the coprocessor port
package cpi_pkg;

    // ==========================================================
    // Widths and field positions
    // ==========================================================
    localparam int unsigned INSTR_W     = 32;
    localparam int unsigned WCOUNT_W    = 4;
    localparam int unsigned DATA_W      = 64;
    localparam int unsigned HALF_W      = 32;
    localparam int unsigned LO_LSB      = 0;
    localparam int unsigned HI_LSB      = 32;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [WCOUNT_W-1:0] WCOUNT_IDLE = 4'h0;
    localparam logic [INSTR_W-1:0]  INSTR_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0]   DATA_RST    = 64'h0000_0000_0000_0000;
    // Bits 27:26 both set mark a coprocessor-class word
    localparam logic [1:0]          CP_CLASS    = 2'h3;
    localparam int unsigned         CLASS_LSB   = 26;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic [WCOUNT_W-1:0] word_count;
        logic                swap;
        logic                dbl;
    } cpi_attr_t;

    typedef struct packed {
        logic [INSTR_W-1:0] word;
        logic               valid;
    } cpi_issue_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_STALL,
        ST_FLUSH
    } cpi_state_t;

    localparam cpi_attr_t ATTR_RST = '{word_count: WCOUNT_IDLE, swap: 1'b0, dbl: 1'b0};

endpackage

// ---- src/cpi_swap.sv ----
// Data word swapper applied to load and store data before writing
`timescale 1ns/10ps
module cpi_swap
    import cpi_pkg::*;
(
    input  wire logic              swap_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o
);

    // ==========================================================
    // Exchange upper and lower words when asked
    // ==========================================================
    always_comb begin
        if (swap_i) begin
            data_o = {data_i[LO_LSB +: HALF_W], data_i[HI_LSB +: HALF_W]};
        end else begin
            data_o = data_i;
        end
    end

endmodule

// ---- src/cpi_core_port.sv ----
// Core end of the coprocessor issue port with transfer attribute capture
`timescale 1ns/10ps

module cpi_core_port
    import cpi_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic [INSTR_W-1:0]    fetch_word_i,
    input  wire logic                  fetch_valid_i,
    input  wire logic                  decode_hold_i,
    input  wire logic                  kill_i,
    input  wire logic                  flush_i,
    input  wire logic                  cp_busy_hold_i,
    input  wire cpi_pkg::cpi_attr_t    cp_attr_i,
    input  wire logic [DATA_W-1:0]     load_data_bus_i,
    input  wire logic [DATA_W-1:0]     store_data_bus_i,
    output logic [INSTR_W-1:0]         issue_instr_word_o,
    output logic                       issue_instr_valid_o,
    output logic                       decode_confirm_valid_o,
    output logic                       decode_stall_hold_o,
    output logic                       pipeline_flush_o,
    output cpi_pkg::cpi_attr_t         attr_o,
    output logic [DATA_W-1:0]          load_data_o,
    output logic [DATA_W-1:0]          store_data_o
);

    import cpi_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic is_cp_word(input logic [INSTR_W-1:0] w);
        is_cp_word = (w[CLASS_LSB +: 2] == CP_CLASS);
    endfunction

    function automatic cpi_state_t stage_after_hold(input logic fl, input logic st);
        if (fl) begin
            stage_after_hold = ST_FLUSH;
        end else if (st) begin
            stage_after_hold = ST_STALL;
        end else begin
            stage_after_hold = ST_RUN;
        end
    endfunction

    cpi_issue_t  issue;
    cpi_issue_t  decode;
    cpi_attr_t   attr_live;
    cpi_attr_t   attr_held;
    cpi_state_t  state;
    logic        stall;
    logic [DATA_W-1:0] load_sw;
    logic [DATA_W-1:0] store_sw;

    // Decode cannot advance under a local hold or a coprocessor busy hold
    assign stall = (decode_hold_i | cp_busy_hold_i) & ~flush_i;

    // ==========================================================
    // Stage control state
    // ==========================================================
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_RUN;
        end else begin
            case (state)
                ST_RUN: begin
                    state <= stage_after_hold(flush_i, stall);
                end
                ST_STALL: begin
                    state <= stage_after_hold(flush_i, stall);
                end
                ST_FLUSH: begin
                    // Emptied stages have nothing to hold for one cycle
                    if (flush_i) begin
                        state <= ST_FLUSH;
                    end else begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Issue stage
    // ==========================================================
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            issue <= '{word: INSTR_RST, valid: 1'b0};
        end else if (flush_i) begin
            issue <= '{word: INSTR_RST, valid: 1'b0};
        end else if (!stall || !issue.valid) begin
            // Prefetch may fill an empty slot even under interlock
            issue.word  <= fetch_word_i;
            issue.valid <= fetch_valid_i & is_cp_word(fetch_word_i);
        end
    end

    // ==========================================================
    // Decode stage and confirm-valid
    // ==========================================================
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            decode <= '{word: INSTR_RST, valid: 1'b0};
        end else if (flush_i) begin
            decode <= '{word: INSTR_RST, valid: 1'b0};
        end else if (!stall) begin
            decode <= issue;
        end else if (kill_i) begin
            // Exception or mispredict withdraws the held instruction
            decode.valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            issue_instr_word_o <= INSTR_RST;
        end else begin
            issue_instr_word_o <= issue.word;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            issue_instr_valid_o <= 1'b0;
        end else begin
            issue_instr_valid_o <= issue.valid & ~flush_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            decode_confirm_valid_o <= 1'b0;
        end else begin
            decode_confirm_valid_o <= decode.valid & ~flush_i & ~kill_i;
        end
    end

    // ==========================================================
    // Decode stall hold and flush, registered
    // ==========================================================
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            decode_stall_hold_o <= 1'b0;
        end else begin
            decode_stall_hold_o <= stall & decode.valid;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pipeline_flush_o <= 1'b0;
        end else begin
            pipeline_flush_o <= flush_i;
        end
    end

    // ==========================================================
    // Transfer attribute capture
    // ==========================================================
    assign attr_live = cp_attr_i;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            attr_held <= ATTR_RST;
        end else if (flush_i) begin
            attr_held <= ATTR_RST;
        end else if (state != ST_STALL) begin
            // Sample in the cycle before the stall hold is driven, keep while stalled
            attr_held <= attr_live;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            attr_o <= ATTR_RST;
        end else if (state == ST_STALL) begin
            attr_o <= attr_held;
        end else begin
            attr_o <= attr_live;
        end
    end

    // ==========================================================
    // Data word swap
    // ==========================================================
    cpi_swap u_load_swap (
        .swap_i (attr_held.swap),
        .data_i (load_data_bus_i),
        .data_o (load_sw)
    );

    cpi_swap u_store_swap (
        .swap_i (attr_held.swap),
        .data_i (store_data_bus_i),
        .data_o (store_sw)
    );

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_data_o  <= DATA_RST;
            store_data_o <= DATA_RST;
        end else begin
            load_data_o  <= load_sw;
            store_data_o <= store_sw;
        end
    end

endmodule

// ---- testbench/cpi_core_port_sva.sv ----
// Assertion checker for the core end of the coprocessor port
`timescale 1ns/10ps
module cpi_core_port_sva
    import cpi_pkg::*;
(
    input wire logic               ref_clk_i,
    input wire logic               rstn_i,
    input wire logic               decode_hold_i,
    input wire logic               kill_i,
    input wire logic               flush_i,
    input wire logic               cp_busy_hold_i,
    input wire logic [DATA_W-1:0]  load_data_bus_i,
    input wire logic [INSTR_W-1:0] issue_instr_word_o,
    input wire logic               issue_instr_valid_o,
    input wire logic               decode_confirm_valid_o,
    input wire logic               decode_stall_hold_o,
    input wire logic               pipeline_flush_o,
    input wire cpi_attr_t          attr_o,
    input wire logic [DATA_W-1:0]  load_data_o
);
    // ==========================================================
    // Properties
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    a_cp_class: assert property (issue_instr_valid_o
        |-> issue_instr_word_o[CLASS_LSB+:2] == CP_CLASS) else $error("issue class");
    a_load_swap: assert property ($past(rstn_i, 2) && !$past(flush_i, 2)
        |-> load_data_o == ($past(attr_o.swap) ? {$past(load_data_bus_i[31:0]),
        $past(load_data_bus_i[63:32])} : $past(load_data_bus_i))) else $error("load order");
    a_flush_clear: assert property (flush_i
        |=> pipeline_flush_o && !issue_instr_valid_o && !decode_confirm_valid_o)
        else $error("flush clear");
    a_stall_cause: assert property (!decode_hold_i && !cp_busy_hold_i
        |=> !decode_stall_hold_o) else $error("stall cause");
    a_stall_src: assert property (decode_stall_hold_o
        |-> $past(decode_hold_i || cp_busy_hold_i)) else $error("stall source");
    a_stall_flush: assert property (flush_i
        |=> !decode_stall_hold_o) else $error("stall flush");
    a_attr_freeze: assert property (decode_stall_hold_o && $past(decode_stall_hold_o)
        && !$past(flush_i) |-> $stable(attr_o)) else $error("attr freeze");
    a_kill_drop: assert property (kill_i && (decode_hold_i || cp_busy_hold_i) && !flush_i
        |=> !decode_confirm_valid_o) else $error("kill drop");
    a_confirm_src: assert property ($rose(decode_confirm_valid_o)
        |-> $past(issue_instr_valid_o)) else $error("confirm source");
    c_confirm: cover property (decode_confirm_valid_o);
    c_stall: cover property (decode_stall_hold_o [*2]);
    c_flush: cover property (flush_i ##1 pipeline_flush_o);
    c_kill: cover property (kill_i && decode_stall_hold_o);
endmodule
bind cpi_core_port cpi_core_port_sva sva (
    .ref_clk_i              (ref_clk_i),
    .rstn_i                 (rstn_i),
    .decode_hold_i          (decode_hold_i),
    .kill_i                 (kill_i),
    .flush_i                (flush_i),
    .cp_busy_hold_i         (cp_busy_hold_i),
    .load_data_bus_i        (load_data_bus_i),
    .issue_instr_word_o     (issue_instr_word_o),
    .issue_instr_valid_o    (issue_instr_valid_o),
    .decode_confirm_valid_o (decode_confirm_valid_o),
    .decode_stall_hold_o    (decode_stall_hold_o),
    .pipeline_flush_o       (pipeline_flush_o),
    .attr_o                 (attr_o),
    .load_data_o            (load_data_o)
);

// ---- testbench/cpi_cp_model.sv ----
// Coprocessor model answering the core with transfer attributes
`timescale 1ns/10ps
module cpi_cp_model
    import cpi_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               issue_instr_valid_i,
    input  wire logic [INSTR_W-1:0] issue_instr_word_i,
    input  wire logic               decode_confirm_valid_i,
    input  wire logic               decode_stall_hold_i,
    input  wire logic               flush_i,
    input  wire logic               slow_i,
    output logic                    cp_busy_hold_o,
    output cpi_attr_t               attr_o,
    output logic [7:0]              confirms_o
);
    // ==========================================================
    // Attributes and confirm capture
    assign cp_busy_hold_o = slow_i && issue_instr_valid_i;
    always_comb begin
        attr_o = ATTR_RST;
        if (issue_instr_valid_i && !flush_i) begin
            attr_o.word_count = issue_instr_word_i[WCOUNT_W-1:0];
            attr_o.swap = issue_instr_word_i[4];
            attr_o.dbl = issue_instr_word_i[WCOUNT_W-1:0] == 4'h2;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) confirms_o <= 8'h00;
        else if (decode_confirm_valid_i && !decode_stall_hold_i && !cp_busy_hold_o && !flush_i)
            confirms_o <= confirms_o + 8'h01;
    end
endmodule

// ---- testbench/tb_cpi_core_port.sv ----
// Testbench for the core end of the coprocessor port
`timescale 1ns/10ps
module tb_cpi_core_port;
    import cpi_pkg::*;
    logic              ref_clk_i = 1'b0, rstn_i = 1'b0, fetch_valid_i = 1'b0, slow = 1'b0;
    logic              decode_hold_i = 1'b0, kill_i = 1'b0, flush_i = 1'b0;
    logic [31:0]       fetch_word_i = INSTR_RST;
    logic [DATA_W-1:0] ld = DATA_RST, st = DATA_RST;
    logic [DATA_W-1:0] ldo, sto;
    logic [31:0]       iw;
    logic              busy, iv, cv, sh, pf;
    logic [7:0]        confirms;
    cpi_attr_t         cattr, attr;
    int                miscompares = 0, total_checks = 0, cycles = 0;
    cpi_core_port dut (.ref_clk_i, .rstn_i, .fetch_word_i, .fetch_valid_i, .decode_hold_i,
        .kill_i, .flush_i, .cp_busy_hold_i(busy), .cp_attr_i(cattr), .load_data_bus_i(ld),
        .store_data_bus_i(st), .issue_instr_word_o(iw), .issue_instr_valid_o(iv),
        .decode_confirm_valid_o(cv), .decode_stall_hold_o(sh), .pipeline_flush_o(pf),
        .attr_o(attr), .load_data_o(ldo), .store_data_o(sto));
    cpi_cp_model cp (.ref_clk_i, .rstn_i, .issue_instr_valid_i(iv), .issue_instr_word_i(iw),
        .decode_confirm_valid_i(cv), .decode_stall_hold_i(sh), .flush_i(pf), .slow_i(slow),
        .cp_busy_hold_o(busy), .attr_o(cattr), .confirms_o(confirms));
    // ==========================================================
    // Clock, timeout and shared tasks
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic feed(input logic [31:0] w, input logic v);
        fetch_word_i = w;
        fetch_valid_i = v;
    endtask
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_issue();
        ld = 64'h0123_4567_89ab_cdef;
        feed(32'h0c00_0002, 1'b1);
        tick(1);
        feed(32'h0000_0001, 1'b1);
        for (int i = 0; i < 4 && iv !== 1'b1; i++) tick(1);
        chk("issue_word", 64'h0c00_0002, 64'(iw));
        tick(1);
        chk("confirm", 1, 64'(cv));
        tick(3);
        chk("noncp_valid", 0, 64'({iv, cv}));
        chk("confirms", 1, 64'(confirms));
        chk("load_plain", 64'h0123_4567_89ab_cdef, ldo);
        feed(32'h0000_0001, 1'b0);
    endtask
    task automatic t_stall();
        feed(32'h0c00_0002, 1'b1);
        tick(1);
        feed(32'h0c00_0002, 1'b0);
        for (int i = 0; i < 6 && iv !== 1'b1; i++) tick(1);
        decode_hold_i = 1'b1;
        feed(32'h0c00_0011, 1'b1);
        tick(4);
        chk("stall_hold", 1, 64'(sh));
        chk("late_issue", 64'h0c00_0011, 64'(iw));
        chk("attr_held", 64'h09, 64'(attr));
        decode_hold_i = 1'b0;
        ld = 64'h1111_2222_3333_4444;
        st = 64'h5555_6666_7777_8888;
        tick(4);
        chk("attr_live", 64'h06, 64'(attr));
        chk("load_swap", 64'h3333_4444_1111_2222, ldo);
        chk("store_swap", 64'h7777_8888_5555_6666, sto);
        feed(32'h0c00_0011, 1'b0);
        tick(5);
        chk("idle_count", 0, 64'(attr.word_count));
    endtask
    task automatic t_busy();
        feed(32'h0c00_0001, 1'b1);
        slow = 1'b1;
        tick(5);
        chk("busy_stall", 1, 64'(sh));
        kill_i = 1'b1;
        tick(1);
        kill_i = 1'b0;
        chk("kill_confirm", 0, 64'(cv));
        slow = 1'b0;
        tick(3);
        flush_i = 1'b1;
        tick(1);
        flush_i = 1'b0;
        chk("flush_clear", 4, 64'({pf, iv, cv}));
        feed(32'h0c00_0001, 1'b0);
        tick(4);
    endtask
    initial begin
        tick(6);
        rstn_i = 1'b1;
        tick(1);
        t_issue();
        t_stall();
        t_busy();
        conclude();
    end
endmodule
